// file: pkg/bmc_ctl_if.sv
// control lines from the register bank to the collision test unit
`timescale 1ns/1ps
interface bmc_ctl_if;
    logic col_test;
    logic isolate;
    logic pdown;
    logic col;
    modport bank (output col_test, output isolate, output pdown, input col);
    modport unit (input col_test, input isolate, input pdown, output col);
endinterface : bmc_ctl_if

// file: pkg/bmc_map.svh
// register offsets, field positions, reset values and timing counts of the control block
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define BMC_OFS_CONTROL 4'h0
`define BMC_OFS_STATE 4'h4
`define BMC_OFS_AN_DONE 4'h8
// ----------------------------------------
// control field positions
// ----------------------------------------
`define BMC_BIT_SPEED 13
`define BMC_BIT_AN_EN 12
`define BMC_BIT_PDOWN 11
`define BMC_BIT_ISOLATE 10
`define BMC_BIT_RESTART 9
`define BMC_BIT_DUPLEX 8
`define BMC_BIT_COLTEST 7
// ----------------------------------------
// state register field positions
// ----------------------------------------
`define BMC_ST_PDOWN 0
`define BMC_ST_ISOLATE 1
`define BMC_ST_FULL 2
`define BMC_ST_FAST 3
`define BMC_ST_AN_BUSY 4
`define BMC_ST_COL 5
// ----------------------------------------
// reset values
// ----------------------------------------
`define BMC_RST_PDOWN 1'b0
`define BMC_RST_ISOLATE 1'b0
`define BMC_RST_COLTEST 1'b0
`define BMC_RST_RESTART 1'b0
// ----------------------------------------
// timing: bit times and clock rate
// ----------------------------------------
`define BMC_CLK_HZ 50000000
`define BMC_BIT_NS_10M 100
`define BMC_COL_ON_BITS 512
`define BMC_COL_OFF_BITS 4
`define BMC_CLK_NS 20
// longest time rounds down: 4 bit times of 100 ns at 20 ns = 20 cycles
`define BMC_COL_OFF_CYC ((`BMC_COL_OFF_BITS * `BMC_BIT_NS_10M) / `BMC_CLK_NS)
`define BMC_COL_ON_CYC ((`BMC_COL_ON_BITS * `BMC_BIT_NS_10M) / `BMC_CLK_NS)
`endif

// file: pkg/bmc_pkg.sv
// types shared by the control block modules
package bmc_pkg;
    typedef enum logic [1:0] {
        BMC_AN_IDLE = 2'b00,
        BMC_AN_START = 2'b01,
        BMC_AN_RUN = 2'b10
    } bmc_an_state_t;
    typedef logic [15:0] bmc_word_t;
endpackage : bmc_pkg

// file: rtl/bmc_bank.sv
// basic mode control register bank with avalon slave and mode outputs
// How it works
// [RL1] power-down bit halts all functions; register block stays reachable (full_duplex and speed_100 here are not gated by it)
// [RL2] low power-down pin sets the power-down bit, ORed with it
// [RL3] isolate bit 10 cuts the mac data interface, management still works
// [RL4] writing 1 to bit 9 restarts negotiation, ignored if bit 12 clear
// [RL5] restart bit reads 1 until negotiation starts, then self-clears
// [RL6] writing 0 to restart bit does not disturb a pending negotiation
// [RL7] duplex bit 8 forces full or half duplex; reset value from strap
// [RL8] collision test bit 7 makes COL follow TX_EN within 512 bit times
// [RL9] COL falls within 4 bit times after TX_EN falls in test mode
// [RL10] bits 6:0 reserved: writes ignored, reads zero
// [RL11] negotiation enable bit 12 overrides forced speed and duplex bits
// [RL12] clearing isolate or power-down returns to normal with no other action
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "bmc_map.svh"
module bmc_bank
    import bmc_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // straps
    input wire logic strap_an_en,
    input wire logic strap_speed,
    input wire logic strap_duplex,
    // pins
    input wire logic power_down_irq_pin_n,
    input wire logic tx_en,
    output logic col,
    // negotiation engine handshake
    output logic an_start,
    input wire logic an_started,
    // operating mode
    output logic power_down,
    output logic isolate,
    output logic full_duplex,
    output logic speed_100,
    output logic an_enable
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic an_en_q;
    logic speed_q;
    logic pdown_q;
    logic isolate_q;
    logic duplex_q;
    logic coltest_q;
    logic strap_taken_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    bmc_an_state_t an_q;
    bmc_an_state_t an_d;
    logic pin_low;
    logic tx_en_s;
    bmc_ctl_if ctl ();
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic pin_s;
    bmc_sync3 #(.RESET_VAL(1'b1)) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .din(power_down_irq_pin_n),
        .dout(pin_s)
    );
    bmc_sync3 #(.RESET_VAL(1'b0)) u_tx_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .din(tx_en),
        .dout(tx_en_s)
    );
    assign pin_low = ~pin_s;
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire req = avs_read | avs_write;
    wire accept = req & ~ack_q;
    wire hit_ctl = (avs_address == `BMC_OFS_CONTROL);
    wire hit_st = (avs_address == `BMC_OFS_STATE);
    wire hit_done = (avs_address == `BMC_OFS_AN_DONE);
    wire hit_any = hit_ctl | hit_st | hit_done;
    wire wr_ctl = accept & avs_write & hit_ctl;
    wire wr_lo = wr_ctl & avs_byteenable[0];
    wire wr_hi = wr_ctl & avs_byteenable[1];
    wire [15:0] wd = avs_writedata[15:0];
    wire restart_req = wr_hi & wd[`BMC_BIT_RESTART] & an_en_q; // [RL4]
    wire restart_pend = (an_q == BMC_AN_START);
    // power-down read back includes the pin
    wire pdown_eff = pdown_q | pin_low; // [RL2]
    bmc_word_t ctl_word;
    always_comb begin
        ctl_word = 16'h0000; // [RL10]
        ctl_word[`BMC_BIT_AN_EN] = an_en_q;
        ctl_word[`BMC_BIT_SPEED] = speed_q;
        ctl_word[`BMC_BIT_PDOWN] = pdown_eff;
        ctl_word[`BMC_BIT_ISOLATE] = isolate_q;
        ctl_word[`BMC_BIT_RESTART] = restart_pend; // [RL5]
        ctl_word[`BMC_BIT_DUPLEX] = duplex_q;
        ctl_word[`BMC_BIT_COLTEST] = coltest_q;
    end
    bmc_word_t st_word;
    always_comb begin
        st_word = 16'h0000;
        st_word[`BMC_ST_PDOWN] = power_down;
        st_word[`BMC_ST_ISOLATE] = isolate;
        st_word[`BMC_ST_FULL] = full_duplex;
        st_word[`BMC_ST_FAST] = speed_100;
        st_word[`BMC_ST_AN_BUSY] = (an_q != BMC_AN_IDLE);
        st_word[`BMC_ST_COL] = col;
    end
    wire [31:0] rd_mux = hit_ctl ? {16'h0000, ctl_word} :
                         hit_st ? {16'h0000, st_word} : 32'h0000_0000;
    // ----------------------------------------
    // negotiation restart sequencer
    // ----------------------------------------
    always_comb begin
        an_d = an_q;
        case (an_q)
            BMC_AN_IDLE: begin
                if (restart_req) begin
                    an_d = BMC_AN_START;
                end
            end
            // a written 0 does not leave this state
            BMC_AN_START: begin
                if (an_started) begin
                    an_d = BMC_AN_RUN; // [RL5] [RL6]
                end
            end
            BMC_AN_RUN: begin
                an_d = BMC_AN_IDLE;
            end
            default: begin
                an_d = BMC_AN_IDLE;
            end
        endcase
    end
    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            pdown_q <= `BMC_RST_PDOWN;
            isolate_q <= `BMC_RST_ISOLATE;
            coltest_q <= `BMC_RST_COLTEST;
            an_q <= BMC_AN_IDLE;
            strap_taken_q <= 1'b0;
            an_en_q <= 1'b0;
            speed_q <= 1'b0;
            duplex_q <= 1'b0;
        end else if (ce) begin
            an_q <= an_d;
            // straps caught on the first enabled edge after release
            if (!strap_taken_q) begin
                strap_taken_q <= 1'b1;
                an_en_q <= strap_an_en;
                speed_q <= strap_speed;
                duplex_q <= strap_duplex; // [RL7]
            end else if (wr_hi) begin
                an_en_q <= wd[`BMC_BIT_AN_EN];
                speed_q <= wd[`BMC_BIT_SPEED];
                duplex_q <= wd[`BMC_BIT_DUPLEX]; // [RL7]
                isolate_q <= wd[`BMC_BIT_ISOLATE]; // [RL3] [RL12]
            end
            // pin low sets the stored bit, and it wins over a clearing write
            if (pin_low) begin
                pdown_q <= 1'b1; // [RL2]
            end else if (wr_hi) begin
                pdown_q <= wd[`BMC_BIT_PDOWN]; // [RL12]
            end
            if (wr_lo) begin
                coltest_q <= wd[`BMC_BIT_COLTEST];
            end
        end
    end
    // ----------------------------------------
    // bus answer: one wait state per access
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'b00;
        end else if (ce) begin
            ack_q <= accept;
            if (accept) begin
                rdata_q <= avs_read ? rd_mux : 32'h0000_0000;
                resp_q <= hit_any ? 2'b00 : 2'b10;
            end
        end
    end
    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;
    // ----------------------------------------
    // mode outputs
    // ----------------------------------------
    assign power_down = pdown_eff; // [RL1]
    assign isolate = isolate_q & ~pdown_eff; // [RL3]
    assign an_enable = an_en_q & ~pdown_eff;
    // forced bits matter only without negotiation
    assign full_duplex = ~an_en_q & duplex_q; // [RL11]
    assign speed_100 = ~an_en_q & speed_q; // [RL11]
    assign an_start = restart_pend & ~pdown_eff;
    assign ctl.col_test = coltest_q;
    assign ctl.isolate = isolate_q;
    assign ctl.pdown = pdown_eff; // [RL1]
    assign col = ctl.col;
    bmc_coltest u_col (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .tx_en(tx_en_s),
        .ctl(ctl)
    );
endmodule : bmc_bank

// file: rtl/bmc_coltest.sv
// collision test unit: echoes transmit enable on the collision output
`timescale 1ns/1ps
`include "bmc_map.svh"
module bmc_coltest (
    // clocking
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // mac side
    input wire logic tx_en,
    // control
    bmc_ctl_if.unit ctl
);
    logic col_q;
    logic col_d;
    // col held low when isolated or powered down
    assign col_d = ctl.col_test & tx_en & ~ctl.isolate & ~ctl.pdown;
    always_ff @(posedge clk) begin
        if (reset) begin
            col_q <= 1'b0;
        end else if (ce) begin
            col_q <= col_d; // [RL8] [RL9]
        end
    end
    assign ctl.col = col_q;
endmodule : bmc_coltest

// file: rtl/bmc_sync3.sv
// three flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module bmc_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    // clocking
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // signal
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            out_q <= RESET_VAL;
        end else if (ce) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // change counts only once second and third agree
            if (s2_q == s3_q) begin
                out_q <= s3_q;
            end
        end
    end
    assign dout = out_q;
endmodule : bmc_sync3

// file: verification/bmc_bank_props.sv
// assertions on the control bank ports
`timescale 1ns/1ps
module bmc_bank_props (
    // clocking
    input wire logic clk,
    input wire logic reset,
    // bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    // pins and modes
    input wire logic power_down_irq_pin_n,
    input wire logic tx_en,
    input wire logic col,
    input wire logic an_start,
    input wire logic an_started,
    input wire logic power_down,
    input wire logic isolate,
    input wire logic an_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire req = avs_read | avs_write;
    wire done = req & ~avs_waitrequest;
    a_wait_once: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not one cycle late");
    a_rsvd_zero: assert property (done && avs_read && avs_address == 4'h0 |-> avs_readdata[6:0] == 7'h0)
        else $error("reserved bits read nonzero");
    a_unmapped_err: assert property (done && avs_address == 4'hc |-> avs_response == 2'h2)
        else $error("unmapped access not refused");
    a_pin_sets: assert property ($fell(power_down_irq_pin_n) |-> ##[1:8] power_down)
        else $error("pin did not power down");
    a_pd_col: assert property (power_down |=> !col)
        else $error("collision while powered down");
    a_iso_col: assert property (isolate |=> !col)
        else $error("collision while isolated");
    a_col_off: assert property ($fell(tx_en) |-> ##[1:20] !col)
        else $error("collision held too long");
    a_an_gate: assert property ($rose(an_start) |-> an_enable)
        else $error("restart with negotiation off");
    a_an_hold: assert property (an_start && !an_started |=> an_start || power_down)
        else $error("restart dropped early");
    a_an_clear: assert property (an_start && an_started |-> ##[1:4] !an_start)
        else $error("restart did not self clear");
endmodule : bmc_bank_props

// file: verification/bmc_bank_tb.sv
// self-checking bench for the basic mode control bank
`timescale 1ns/1ps
`include "bmc_map.svh"
module bmc_bank_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic [1:0] avs_response, rsp;
    logic avs_waitrequest, tx_en, col, an_start, an_started;
    logic power_down, isolate, full_duplex, speed_100, an_enable;
    logic [2:0] strap = 3'h0;
    logic power_down_irq_pin_n = 1'b1;
    logic [15:0] v;
    int fail_count = 0;
    int n_tests = 0;
    bmc_bank i_dut (.clk(clk), .reset(reset), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .strap_an_en(strap[1]), .strap_speed(strap[2]),
        .strap_duplex(strap[0]), .power_down_irq_pin_n(power_down_irq_pin_n), .tx_en(tx_en),
        .col(col), .an_start(an_start), .an_started(an_started), .power_down(power_down),
        .isolate(isolate), .full_duplex(full_duplex), .speed_100(speed_100),
        .an_enable(an_enable));
    bmc_mac_model i_mac (.clk(clk), .tx_en(tx_en), .col(col), .an_start(an_start),
        .an_started(an_started));
    initial forever #10 clk = ~clk;
    // ----
    // helpers
    // ----
    function automatic logic [31:0] exp_ctl(input logic [15:0] w);
        return {16'h0, w & 16'h3d80};
    endfunction : exp_ctl
    // wide enough for a flag or two packed above the read word
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    // ----
    // sequence
    // ----
    initial begin
        void'($urandom(32'h4e55));
        strap = 3'($urandom);
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, exp_ctl({2'b00, strap[2:1], 3'b000, strap[0], 8'h00}));
        for (int i = 0; i < 6; i++) begin
            v = 16'($urandom) & 16'hf1ff;
            bus(1'b1, 4'h0, {16'($urandom), v});
            bus(1'b0, 4'h0, 32'h0);
            chk(rd, exp_ctl(v));
            chk(full_duplex, v[8] & ~v[12]);
            chk(speed_100, v[13] & ~v[12]);
        end
        bus(1'b0, 4'hc, 32'h0);
        chk({rsp, rd}, 34'h2_0000_0000);
        // restart gate looks at the stored enable, so clear it first
        bus(1'b1, 4'h0, 32'h0000);
        bus(1'b1, 4'h0, 32'h0200);
        bus(1'b0, 4'h0, 32'h0);
        chk({an_start, rd}, 33'h0);
        i_mac.an_hold = 1'b1;
        bus(1'b1, 4'h0, 32'h1000);
        bus(1'b1, 4'h0, 32'h1200);
        bus(1'b0, 4'h0, 32'h0);
        chk({an_start, rd}, 33'h1_0000_1200);
        bus(1'b1, 4'h0, 32'h1000);
        bus(1'b0, 4'h0, 32'h0);
        chk({an_start, rd}, 33'h1_0000_1200);
        i_mac.an_hold = 1'b0;
        repeat (8) @(posedge clk);
        bus(1'b0, 4'h0, 32'h0);
        chk({an_start, rd}, 33'h0_0000_1000);
        power_down_irq_pin_n <= 1'b0;
        bus(1'b1, 4'h0, 32'h0080);
        repeat (10) @(posedge clk);
        bus(1'b0, 4'h0, 32'h0);
        chk({power_down, rd}, 33'h1_0000_0880);
        i_mac.send(60);
        chk(i_mac.col_on, -1);
        power_down_irq_pin_n <= 1'b1;
        repeat (10) @(posedge clk);
        // isolate then clear; col must resume with no other action
        bus(1'b1, 4'h0, 32'h0480);
        bus(1'b0, 4'h0, 32'h0);
        chk({power_down, isolate, rd}, 34'h1_0000_0480);
        bus(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h0000_0002);
        i_mac.send(60);
        chk(i_mac.col_on, -1);
        bus(1'b1, 4'h0, 32'h0080);
        bus(1'b0, 4'h0, 32'h0);
        chk({power_down, isolate}, 2'b00);
        for (int i = 0; i < 4; i++) begin
            i_mac.send(40 + int'($urandom % 200));
            chk(i_mac.col_on >= 0 && i_mac.col_on < `BMC_COL_ON_CYC, 1);
            chk(i_mac.col_off >= 0 && i_mac.col_off <= `BMC_COL_OFF_CYC, 1);
        end
        bus(1'b1, 4'h0, 32'h0);
        i_mac.send(60);
        chk(i_mac.col_on, -1);
        final_report();
    end
    initial begin
        repeat (50000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule : bmc_bank_tb
bind bmc_bank bmc_bank_props i_props (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .power_down_irq_pin_n(power_down_irq_pin_n), .tx_en(tx_en), .col(col),
    .an_start(an_start), .an_started(an_started), .power_down(power_down),
    .isolate(isolate), .an_enable(an_enable));

// file: verification/bmc_mac_model.sv
// mac and negotiation engine facing the control block
`timescale 1ns/1ps
module bmc_mac_model (
    // clocking
    input wire logic clk,
    // mac side
    output logic tx_en,
    input wire logic col,
    // negotiation engine
    input wire logic an_start,
    output logic an_started
);
    logic an_hold = 1'b0;
    int col_on;
    int col_off;
    initial begin
        tx_en = 1'b0;
        an_started = 1'b0;
    end
    // engine pulses its start; hold lets a restart stay pending
    always @(posedge clk) an_started <= an_start & ~an_hold & ~an_started;
    // one frame; cycles until col rises, then until it falls
    task automatic send(input int len);
        tx_en <= 1'b1;
        col_on = -1;
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            if (col && col_on < 0) col_on = i;
        end
        tx_en <= 1'b0;
        col_off = -1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (!col && col_off < 0) col_off = i;
        end
    endtask : send
endmodule : bmc_mac_model
